// ---- inc/sbx_pkg.sv ----
/*
  sbx_pkg: shared types and constants of the skip/branch/or execution
  slice of an 8-bit core. Assumes a 14-bit instruction word and a 15-bit
  program counter in the surrounding core.
*/
package sbx_pkg;
  localparam int unsigned INSTR_W   = 14;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned FADDR_W   = 7;
  localparam int unsigned PC_W      = 15;
  localparam int unsigned LATCH_W   = 7;
  localparam int unsigned BRANCH_W  = 11;
  // field positions inside the instruction word and the upper latch
  localparam int unsigned DEST_BIT  = 7;
  localparam int unsigned LATCH_LO  = 3;
  localparam int unsigned LATCH_HI  = 6;
  // opcode patterns: file ops match bits 13:8, literal op bits 13:8,
  // branch bits 13:11
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_INC      = 6'h0a;
  localparam logic [5:0] OPC_OR_FILE  = 6'h04;
  localparam logic [5:0] OPC_OR_LIT   = 6'h38;
  localparam logic [2:0] OPC_BRANCH   = 3'h5;
  // reset values and the destination bit value that selects the accumulator
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic              ZERO_RESET = 1'b0;
  localparam logic              DEST_ACC   = 1'b0;

  typedef enum logic [2:0] {
    SBX_OP_NONE      = 3'b000,
    SBX_OP_DEC_SKIP  = 3'b001,
    SBX_OP_INC_SKIP  = 3'b010,
    SBX_OP_INC       = 3'b011,
    SBX_OP_OR_FILE   = 3'b100,
    SBX_OP_OR_LIT    = 3'b101,
    SBX_OP_BRANCH    = 3'b110
  } sbx_op_t;

  typedef enum logic [0:0] {
    SBX_RUN   = 1'b0,
    SBX_FLUSH = 1'b1
  } sbx_phase_t;

  // instruction issued to the slice, with its operand fetch result
  typedef struct packed {
    logic               valid;
    logic [INSTR_W-1:0] word;
    logic [DATA_W-1:0]  file_data;
    logic [LATCH_W-1:0] upper_latch;
  } sbx_issue_t;

  // write-back towards the data register file
  typedef struct packed {
    logic               we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } sbx_file_wr_t;

  // program counter redirect
  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] target;
  } sbx_pc_wr_t;
endpackage : sbx_pkg

// ---- rtl/sbx_exec.sv ----
/*
  sbx_exec: executes increment with optional skip, decrement with skip, inclusive OR
  with literal or file register, and the unconditional branch.
  Assumes the core presents one instruction per cycle together with the
  value of the addressed file register and the program counter upper
  latch, all synchronous to clock_i.
  The slice has no write-back forwarding path, so the core must present
  file data that already holds a write made in the previous cycle.
  Opcodes outside the slice only raise unsupported_o for one cycle.
*/
// Function
// - file-register results go to the accumulator when the destination bit is 0 and back to the file register when it is 1.
// - decrement-and-skip stores f minus one and, on a zero result, executes the next instruction as a no-operation, with flags unchanged.
// - increment-and-skip stores f plus one and, on a zero result, executes the next instruction as a no-operation, with flags unchanged.
// - the branch loads its 11-bit literal into counter bits 10..0 and bits 14..11 from latch bits 6..3, taking two cycles, flags unchanged.
// - or-literal ORs the accumulator with an 8-bit literal into the accumulator and updates the zero flag.
// - plain increment stores f plus one at the chosen destination without skipping and updates the zero flag.
// - or-file ORs the accumulator with f into the chosen destination and updates the zero flag.
module sbx_exec (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire sbx_pkg::sbx_issue_t   issue_i,
  output logic [sbx_pkg::DATA_W-1:0] acc_o,
  output logic                       zero_o,
  output sbx_pkg::sbx_file_wr_t      file_wr_o,
  output sbx_pkg::sbx_pc_wr_t        pc_wr_o,
  output logic                       no_operation_o,
  output logic                       unsupported_o
);
  import sbx_pkg::*;

  typedef struct packed {
    sbx_phase_t        phase;
    logic [DATA_W-1:0] acc;
    logic              zero;
    sbx_file_wr_t      file_wr;
    sbx_pc_wr_t        pc_wr;
    logic              no_operation;
    logic              unsupported;
  } sbx_state_t;

  sbx_state_t state;
  sbx_state_t next_state;

  function automatic sbx_op_t decode_op(input logic [INSTR_W-1:0] w);
    sbx_op_t op;
    op = SBX_OP_NONE;
    if (w[13:11] == OPC_BRANCH) begin
      op = SBX_OP_BRANCH;
    end else begin
      unique case (w[13:8])
        OPC_DEC_SKIP: op = SBX_OP_DEC_SKIP;
        OPC_INC_SKIP: op = SBX_OP_INC_SKIP;
        OPC_INC:      op = SBX_OP_INC;
        OPC_OR_FILE:  op = SBX_OP_OR_FILE;
        OPC_OR_LIT:   op = SBX_OP_OR_LIT;
        default:      op = SBX_OP_NONE;
      endcase
    end
    return op;
  endfunction : decode_op

  // skip forms squash their follower only when the result is zero
  function automatic logic is_skip_op(input sbx_op_t o);
    return (o == SBX_OP_DEC_SKIP) || (o == SBX_OP_INC_SKIP);
  endfunction : is_skip_op

  function automatic logic is_zero8(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction : is_zero8

  sbx_op_t             op;
  logic [DATA_W-1:0]   result;
  logic                dest_file;
  logic                writes_dest;
  logic                affects_zero;
  logic                skip_taken;
  logic                is_zero;
  logic                is_branch;
  logic [PC_W-1:0]     branch_target;

  // skip and plain forms each compute their own sum or difference in a separate case arm
  always_comb begin
    op            = decode_op(issue_i.word);
    dest_file     = issue_i.word[DEST_BIT];
    is_branch     = (op == SBX_OP_BRANCH);
    result        = '0;
    writes_dest   = 1'b0;
    affects_zero  = 1'b0;
    skip_taken    = 1'b0;
    // the counter redirect is formed every cycle and used only on a branch
    branch_target = {issue_i.upper_latch[LATCH_HI:LATCH_LO],
                     issue_i.word[BRANCH_W-1:0]};
    unique case (op)
      SBX_OP_DEC_SKIP: begin
        result      = issue_i.file_data - 8'h01;
        writes_dest = 1'b1;
      end
      SBX_OP_INC_SKIP: begin
        result      = issue_i.file_data + 8'h01;
        writes_dest = 1'b1;
      end
      SBX_OP_INC: begin
        result       = issue_i.file_data + 8'h01;
        writes_dest  = 1'b1;
        affects_zero = 1'b1;
      end
      SBX_OP_OR_FILE: begin
        result       = state.acc | issue_i.file_data;
        writes_dest  = 1'b1;
        affects_zero = 1'b1;
      end
      SBX_OP_OR_LIT: begin
        result       = state.acc | issue_i.word[DATA_W-1:0];
        affects_zero = 1'b1;
      end
      SBX_OP_BRANCH: begin
        // a branch has no data result and leaves the zero flag alone
        result = '0;
      end
      SBX_OP_NONE: begin
        // foreign codes produce no result in this slice
        result = '0;
      end
    endcase
    is_zero    = is_zero8(result);
    skip_taken = is_zero && is_skip_op(op);
  end

  always_comb begin
    next_state             = state;
    next_state.file_wr.we  = 1'b0;
    next_state.pc_wr.load  = 1'b0;
    next_state.no_operation         = 1'b0;
    next_state.unsupported = 1'b0;
    unique case (state.phase)
      SBX_RUN: begin
        if (issue_i.valid) begin
          if (op == SBX_OP_NONE) begin
            // codes outside this slice belong to other execution units
            next_state.unsupported = 1'b1;
          end
          if (writes_dest) begin
            if (dest_file != DEST_ACC) begin
              next_state.file_wr.we   = 1'b1;
              next_state.file_wr.addr = issue_i.word[FADDR_W-1:0];
              next_state.file_wr.data = result;
            end else begin
              next_state.acc = result;
            end
          end
          if (op == SBX_OP_OR_LIT) begin
            next_state.acc = result;
          end
          if (affects_zero) begin
            next_state.zero = is_zero;
          end
          // the target register holds after the load pulse for the core
          if (is_branch) begin
            next_state.pc_wr.load   = 1'b1;
            next_state.pc_wr.target = branch_target;
          end
          // the fetched follower is squashed: that is the second cycle
          if (skip_taken || is_branch) begin
            next_state.phase = SBX_FLUSH;
          end
        end
      end
      SBX_FLUSH: begin
        // the follower is consumed as a no-operation, nothing is written
        // idle cycles keep the squash owed, since the core may stall
        // between the skip and its follower
        if (issue_i.valid) begin
          next_state.no_operation   = 1'b1;
          next_state.phase = SBX_RUN;
        end
      end
    endcase
  end


  // reset clears every field, so write-back address and data start at zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state.phase         <= SBX_RUN;
      state.acc           <= ACC_RESET;
      state.zero          <= ZERO_RESET;
      state.file_wr       <= '0;
      state.pc_wr         <= '0;
      state.no_operation           <= 1'b0;
      state.unsupported   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end


  // every output is a field of the state register, with no logic after it
  assign acc_o          = state.acc;
  assign zero_o         = state.zero;
  assign file_wr_o      = state.file_wr;
  assign pc_wr_o        = state.pc_wr;
  assign no_operation_o = state.no_operation;
  assign unsupported_o  = state.unsupported;
endmodule : sbx_exec

// ---- tb/sbx_exec_assertions.sv ----
/* checker of sbx_exec; sees only its ports, bound to every instance */
module sbx_exec_assertions (
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  input wire sbx_pkg::sbx_issue_t   issue_i,
  input wire logic [7:0]            acc_o,
  input wire logic                  zero_o,
  input wire sbx_pkg::sbx_file_wr_t file_wr_o,
  input wire sbx_pkg::sbx_pc_wr_t   pc_wr_o,
  input wire logic                  no_operation_o,
  input wire logic                  unsupported_o
);
  import sbx_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [13:0] w;
  logic [7:0]  fd;
  logic [5:0]  op;
  logic        t;
  logic        pend;
  assign w = issue_i.word;
  assign fd = issue_i.file_data;
  assign op = w[13:8];
  assign t = issue_i.valid && !pend;
  // squash owed after a zero skip or a branch, kept over idle cycles
  always_ff @(posedge clock_i) begin
    if (rst_i) pend <= 1'b0;
    else if (issue_i.valid) pend <= t && (w[13:11] == OPC_BRANCH
      || (op == OPC_DEC_SKIP && fd == 8'h01)
      || (op == OPC_INC_SKIP && fd == 8'hff));
  end
  sequence s_squash;
    issue_i.valid && pend;
  endsequence
  a_acc_dest:
    assert property (t && op == OPC_INC && !w[7] |=> !file_wr_o.we
      && acc_o == $past(fd) + 8'h01) else $error("acc dest");
  a_file_dest:
    assert property (t && op == OPC_OR_FILE && w[7] |=> file_wr_o.we
      && file_wr_o.addr == $past(w[6:0])
      && file_wr_o.data == ($past(acc_o) | $past(fd))) else $error("dest");
  a_dec_skip:
    assert property (t && op == OPC_DEC_SKIP && !w[7] |=>
      acc_o == $past(fd) - 8'h01 && $stable(zero_o)) else $error("dec");
  a_inc_skip:
    assert property (t && op == OPC_INC_SKIP && w[7] |=>
      file_wr_o.data == $past(fd) + 8'h01 && $stable(zero_o))
      else $error("inc skip");
  a_squash_slot:
    assert property (s_squash |=> no_operation_o && !file_wr_o.we
      && !pc_wr_o.load) else $error("squash");
  a_branch_target:
    assert property (t && w[13:11] == OPC_BRANCH |=> pc_wr_o.load
      && pc_wr_o.target == {$past(issue_i.upper_latch[6:3]), $past(w[10:0])}
      && $stable(zero_o)) else $error("branch");
  a_or_literal:
    assert property (t && op == OPC_OR_LIT |=> acc_o == ($past(acc_o)
      | $past(w[7:0])) && zero_o == (acc_o == 8'h00)) else $error("or lit");
  a_inc_zero:
    assert property (t && op == OPC_INC |=> !no_operation_o
      && zero_o == ($past(fd) == 8'hff)) else $error("inc zero");
endmodule : sbx_exec_assertions
bind sbx_exec sbx_exec_assertions i_chk (.clock_i(clock_i), .rst_i(rst_i),
  .issue_i(issue_i), .acc_o(acc_o), .zero_o(zero_o), .file_wr_o(file_wr_o),
  .pc_wr_o(pc_wr_o), .no_operation_o(no_operation_o),
  .unsupported_o(unsupported_o));

// ---- tb/sbx_file_model.sv ----
/* data register file model; expects write-back pulses at clock edges */
module sbx_file_model (
  input  wire logic                 clock_i,
  input  wire sbx_pkg::sbx_file_wr_t file_wr_i,
  input  wire logic [6:0]           addr_i,
  output logic      [7:0]           data_o
);
  import sbx_pkg::*;
  logic [7:0] mem [128];
  // the slice has no bypass, so last cycle's write is forwarded here
  assign data_o = (file_wr_i.we && file_wr_i.addr == addr_i)
    ? file_wr_i.data : mem[addr_i];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) - 8'h01;
  always @(posedge clock_i) if (file_wr_i.we) mem[file_wr_i.addr] <= file_wr_i.data;
endmodule : sbx_file_model

// ---- tb/skip_branch_logic_instr_exec_tb.sv ----
/* bench of sbx_exec; a file model supplies operands, one clock */
module skip_branch_logic_instr_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sbx_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, v = 1'b0;
  logic [13:0] w = '0;
  logic [6:0] lat = '0;
  logic [7:0] fd, acc_o, ea, f, r, mref [128];
  logic zero_o, no_operation, uns, ez, ep, ewe, eld, enop, eun;
  logic [14:0] ef, et;
  logic [31:0] seed = 32'hede8;
  int miscompares = 0, checks = 0, cyc = 0;
  sbx_file_wr_t fw;
  sbx_pc_wr_t pw;
  logic [5:0] tb [8] = '{6'h0b, 6'h0f, 6'h0a, 6'h04, 6'h38, 6'h28, 6'h2f, 6'h3f};
  logic [14:0] cw [12] = '{15'h4a80, 15'h4b80, 15'h4f80, 15'h3801, 15'h78ff,
    15'h4b02, 15'h6abc, 15'h6abc, 15'h7800, 15'h7800, 15'h4481, 15'h7fff};
  sbx_exec i_dut (.clock_i(clock_i), .rst_i(rst_i), .issue_i({v, w, fd, lat}),
    .acc_o(acc_o), .zero_o(zero_o), .file_wr_o(fw), .pc_wr_o(pw),
    .no_operation_o(no_operation), .unsupported_o(uns));
  sbx_file_model i_mem (.clock_i(clock_i), .file_wr_i(fw), .addr_i(w[6:0]),
    .data_o(fd));
  always #12.5 clock_i = ~clock_i;
  initial for (int i = 0; i < 128; i++) mref[i] = 8'(i) - 8'h01;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] res(input logic [13:0] i, logic [7:0] a, b);
    return i[13:8] == OPC_DEC_SKIP ? b - 8'h01 : i[13:8] == OPC_OR_FILE ?
      a | b : i[13:8] == OPC_OR_LIT ? a | i[7:0] : b + 8'h01;
  endfunction : res
  always @(posedge clock_i) begin
    {ewe, eld, enop, eun} = '0;
    f = mref[w[6:0]];
    r = res(w, ea, f);
    if (rst_i) {ea, ez, ep} = '0;
    else if (v && ep) {ep, enop} = 2'b01;
    else if (v) begin
      if (w[13:11] == OPC_BRANCH) {eld, ep, et} = {2'b11, lat[6:3], w[10:0]};
      else if (w[13:8] == OPC_OR_LIT) {ea, ez} = {r, r == 8'h00};
      else if (w[13:8] inside {OPC_DEC_SKIP, OPC_INC_SKIP, OPC_INC,
        OPC_OR_FILE}) begin
        if (w[7]) {ewe, mref[w[6:0]], ef} = {1'b1, r, w[6:0], r};
        else ea = r;
        if (w[13:8] inside {OPC_INC, OPC_OR_FILE}) ez = r == 8'h00;
        else ep = r == 8'h00;
      end else eun = 1'b1;
    end
  end
  task automatic chk(input logic [42:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] outputs expected %h seen %h", e, g);
    end
  endtask : chk
  always @(negedge clock_i) if (!rst_i) chk({ea, ez, ewe, eld, enop, eun,
    ewe ? ef : 15'h0, eld ? et : 15'h0}, {acc_o, zero_o, fw.we, pw.load, no_operation,
    uns, ewe ? {fw.addr, fw.data} : 15'h0, eld ? pw.target : 15'h0});
  task automatic put(input logic val, input logic [13:0] wd);
    @(posedge clock_i);
    v <= val;
    w <= wd;
    lat <= seed[30:24];
  endtask : put
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clock_i) if (++cyc == 2000) begin
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (cw[i]) put(cw[i][14], cw[i][13:0]);
    $display("test corner done");
    repeat (600) begin
      seed = xs(seed);
      put(seed[0] | seed[1], {tb[seed[4:2]], seed[15:8]});
    end
    $display("test random done");
    put(1'b0, 14'h0);
    repeat (2) @(posedge clock_i);
    print_verdict();
  end
endmodule : skip_branch_logic_instr_exec_tb
